// ==== scr_clock_ctrl.sv ====
// Secondary oscillator control and divided reference clock output.
// Assumes synchronous inputs; oscillator and system clocks come as ticks.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RQ1] Peripheral demand starts the secondary oscillator without the manual enable.
// [RQ2] Manual enable starts the secondary oscillator ahead of any demand.
// [RQ3] Oscillator runs only with mode codes 11 or 01.
// [RQ4] Mode 00 makes oscillator pins digital I/O; oscillating modes forbid it.
// [RQ5] Mode 01 selects low drive; other oscillating mode uses high drive.
// [RQ6] External clock mode clocks modules from input pin; driver off, manual enable ignored.
// [RQ7] Output enable bit 15 drives the divided clock onto the output pin.
// [RQ8] Divisor field bits 11:8 selects among sixteen ratios; the code clamps codes below 0101 to 32, leaving eleven.
// [RQ9] Divisor is a power of two: 1111 is 32768, 0101 is 32.
// [RQ10] Source select picks primary oscillator or system clock as base clock.
// [RQ11] Source select 1 is primary oscillator, 0 is the switching system clock.
// [RQ12] Sleep control bit decides whether the output runs during Sleep.
// [RQ13] Sleep bit 1 keeps output running in Sleep; 0 disables it.
// [RQ14] Output present in Sleep only with sleep bit and source select both set.
// [RQ15] Sleep powers down primary oscillator unless keep bit set, stopping its output.
// [RQ16] With source select clear, output follows system clock switches at once.
// [RQ17] Reference output works in every oscillator configuration.
// [RQ18] Control bits reset to zero; bit 14 and bits 7:0 read zero.
module scr_clock_ctrl
   import scr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [SCR_AW-1:0] busAddr,
   input wire logic [SCR_DW-1:0] busWrData,
   input wire logic busWrStb,
   input wire logic busRdStb,
   output logic [SCR_DW-1:0] busRdData,
   input wire logic periphDemand,
   input wire logic sleepMode,
   input wire logic systemTick,
   input wire logic primaryTick,
   input wire logic secondaryXtalTick,
   input wire logic secondaryExtClockIn,
   output scr_secondary_oscillator_t soscOut,
   output logic primaryOscRun,
   output logic refClockOut,
   output logic refClockOe_n
);

   function automatic logic [SCR_CNT_W-1:0] halfTicks(input logic [3:0] code);
      logic [3:0] c;
      c = (code < SCR_DIV_MIN_CODE) ? SCR_DIV_MIN_CODE : code;
      return SCR_CNT_W'(1) << (c - 4'h1);
   endfunction

   scr_ref_ctl_t refCtl_reg;
   logic manEn_reg;
   logic primaryKeep_reg;
   scr_mode_t mode_reg;
   logic [SCR_DW-1:0] rdData_reg;
   scr_secondary_oscillator_t secondary_oscillator_reg;
   scr_secondary_oscillator_t secondary_oscillator_next;
   logic primaryRun_reg;
   logic refOut_reg;
   logic refOe_n_reg;
   logic [SCR_CNT_W-1:0] divCnt_reg;
   logic extPrev_reg;

   logic oscModeOn;
   logic extMode;
   logic extRise;
   logic refAllowed;
   logic baseTick;
   logic divWrap;
   logic [SCR_DW-1:0] refCtlRead;
   logic [SCR_DW-1:0] statusRead;

   // Register writes
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         refCtl_reg <= '{SCR_BIT_RST, SCR_BIT_RST, SCR_BIT_RST, SCR_REF_DIV_RST}; // RQ18
      end else if (busWrStb && busAddr == SCR_REG_REFCTL) begin
         refCtl_reg.outEnable <= busWrData[SCR_REF_EN_BIT]; // RQ7
         refCtl_reg.runInSleep <= busWrData[SCR_REF_SLP_BIT]; // RQ12
         refCtl_reg.sourceSelect <= busWrData[SCR_REF_SEL_BIT]; // RQ10
         refCtl_reg.divisor <= busWrData[SCR_REF_DIV_LSB +: 4]; // RQ8
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         manEn_reg <= SCR_BIT_RST;
         primaryKeep_reg <= SCR_BIT_RST;
      end else if (busWrStb && busAddr == SCR_REG_OSCCTL) begin
         manEn_reg <= busWrData[SCR_OSC_MANEN_BIT]; // RQ2
         primaryKeep_reg <= busWrData[SCR_OSC_PKEEP_BIT]; // RQ15
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mode_reg <= scr_mode_t'(SCR_MODE_RST);
      end else if (busWrStb && busAddr == SCR_REG_SOSCCFG) begin
         mode_reg <= scr_mode_t'(busWrData[SCR_SECONDARY_OSCILLATOR_MODE_LSB +: 2]); // RQ3
      end
   end

   // Read path; data stand only in the cycle after the strobe
   always_comb begin
      refCtlRead = '0;
      refCtlRead[SCR_REF_EN_BIT] = refCtl_reg.outEnable;
      refCtlRead[SCR_REF_SLP_BIT] = refCtl_reg.runInSleep;
      refCtlRead[SCR_REF_SEL_BIT] = refCtl_reg.sourceSelect;
      refCtlRead[SCR_REF_DIV_LSB +: 4] = refCtl_reg.divisor;
      statusRead = '0;
      statusRead[SCR_STS_OSC_ON] = secondary_oscillator_reg.oscEnable;
      statusRead[SCR_STS_LOWPWR] = secondary_oscillator_reg.lowPower;
      statusRead[SCR_STS_DIGIO] = secondary_oscillator_reg.pinsDigital;
      statusRead[SCR_STS_REF_ON] = ~refOe_n_reg;
      statusRead[SCR_STS_PRI_ON] = primaryRun_reg;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !busRdStb) begin
         rdData_reg <= '0;
      end else begin
         unique case (busAddr)
            SCR_REG_REFCTL: rdData_reg <= refCtlRead & SCR_REFCTL_MASK; // RQ18
            SCR_REG_OSCCTL: begin
               rdData_reg <= '0;
               rdData_reg[SCR_OSC_MANEN_BIT] <= manEn_reg;
               rdData_reg[SCR_OSC_PKEEP_BIT] <= primaryKeep_reg;
            end
            SCR_REG_SOSCCFG: begin
               rdData_reg <= '0;
               rdData_reg[SCR_SECONDARY_OSCILLATOR_MODE_LSB +: 2] <= mode_reg;
            end
            SCR_REG_STATUS: rdData_reg <= statusRead;
         endcase
      end
   end

   // Secondary oscillator
   assign oscModeOn = (mode_reg == SCR_MODE_HIPWR) || (mode_reg == SCR_MODE_LOWPWR); // RQ3
   assign extMode = (mode_reg == SCR_MODE_EXTCLK);
   assign extRise = secondaryExtClockIn & ~extPrev_reg;

   always_comb begin
      // Manual enable has no say outside the oscillating modes
      secondary_oscillator_next.oscEnable = oscModeOn & (periphDemand | manEn_reg); // RQ1 RQ2 RQ6
      secondary_oscillator_next.lowPower = (mode_reg == SCR_MODE_LOWPWR); // RQ5
      secondary_oscillator_next.pinsDigital = (mode_reg == SCR_MODE_DIGIO); // RQ4
      if (oscModeOn) begin
         secondary_oscillator_next.clockTick = secondary_oscillator_reg.oscEnable & secondaryXtalTick;
      end else begin
         secondary_oscillator_next.clockTick = extMode & extRise; // RQ6
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         secondary_oscillator_reg <= '0;
         extPrev_reg <= 1'b0;
      end else begin
         secondary_oscillator_reg <= secondary_oscillator_next;
         extPrev_reg <= secondaryExtClockIn;
      end
   end

   // Primary oscillator power in Sleep
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         primaryRun_reg <= 1'b1;
      end else begin
         primaryRun_reg <= ~sleepMode | primaryKeep_reg; // RQ15
      end
   end

   // Reference output; no dependence on oscillator configuration
   assign refAllowed = refCtl_reg.outEnable &
      (~sleepMode | (refCtl_reg.runInSleep & refCtl_reg.sourceSelect)); // RQ7 RQ13 RQ14 RQ17
   // A powered-down primary gives no ticks, so its output freezes
   assign baseTick = refCtl_reg.sourceSelect ? (primaryTick & primaryRun_reg) : systemTick; // RQ11 RQ15 RQ16
   assign divWrap = divCnt_reg >= (halfTicks(refCtl_reg.divisor) - SCR_CNT_W'(1)); // RQ9

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !refAllowed) begin
         divCnt_reg <= '0;
         refOut_reg <= 1'b0;
      end else if (baseTick) begin
         if (divWrap) begin
            // Wrap on >= so a smaller divisor takes effect at once
            divCnt_reg <= '0;
            refOut_reg <= ~refOut_reg; // RQ8 RQ9
         end else begin
            divCnt_reg <= divCnt_reg + SCR_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         refOe_n_reg <= 1'b1;
      end else begin
         refOe_n_reg <= ~refAllowed; // RQ7 RQ13
      end
   end

   assign busRdData = rdData_reg;
   assign soscOut = secondary_oscillator_reg;
   assign primaryOscRun = primaryRun_reg;
   assign refClockOut = refOut_reg;
   assign refClockOe_n = refOe_n_reg;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   AST_AUTO_START: assert property (periphDemand && oscModeOn |=> soscOut.oscEnable) // RQ1
      else $error("demand did not start oscillator");
   AST_MANUAL_START: assert property (manEn_reg && oscModeOn |=> soscOut.oscEnable) // RQ2
      else $error("manual enable did not start oscillator");
   AST_MODE_GATE: assert property (!oscModeOn |=> !soscOut.oscEnable) // RQ3
      else $error("oscillator on in non-oscillating mode");
   AST_DIGIO: assert property (oscModeOn |=> !soscOut.pinsDigital && !$past(extMode)) // RQ4
      else $error("digital pins in oscillating mode");
   AST_LOWPWR: assert property (mode_reg == SCR_MODE_LOWPWR |=> soscOut.lowPower && soscOut.oscEnable == $past(periphDemand | manEn_reg)) // RQ5
      else $error("low power mode wrong");
   AST_EXT_TICK: assert property (extMode && extRise |=> soscOut.clockTick && !soscOut.oscEnable) // RQ6
      else $error("external clock edge not passed");
   AST_REF_OE: assert property (refCtl_reg.outEnable && !sleepMode |=> !refClockOe_n) // RQ7
      else $error("reference output not driven");
   AST_DIV_TOGGLE: assert property (refAllowed && baseTick && divWrap |=> refClockOut != $past(refClockOut)) // RQ8
      else $error("divider did not toggle");
   AST_DIV_HALF: assert property (refAllowed && refCtl_reg.divisor == 4'h5 && divCnt_reg < SCR_CNT_W'(15) |-> !divWrap) // RQ9
      else $error("divide by 32 wraps early");
   AST_SLEEP_OFF: assert property (sleepMode && !(refCtl_reg.runInSleep && refCtl_reg.sourceSelect) |=> refClockOe_n && !refClockOut) // RQ13
      else $error("reference output alive in sleep");
   AST_PRI_DOWN: assert property (sleepMode && !primaryKeep_reg ##1 refCtl_reg.sourceSelect |-> !baseTick) // RQ15
      else $error("primary ticks while powered down");
   AST_READ_ZERO: assert property (busRdStb && busAddr == SCR_REG_REFCTL |=> busRdData[14] == 1'b0 && busRdData[7:0] == 8'h00) // RQ18
      else $error("reserved bits read nonzero");

   // Oscillator mode and tick checks
   AST_DIGIO_ON: assert property (mode_reg == SCR_MODE_DIGIO |=> soscOut.pinsDigital) // RQ4
      else $error("digital pins not released in mode 00");
   AST_EXT_NOT_DIGIO: assert property (extMode |=> !soscOut.pinsDigital) // RQ4
      else $error("digital pins in external clock mode");
   AST_HIPWR: assert property (mode_reg == SCR_MODE_HIPWR |=> !soscOut.lowPower) // RQ5
      else $error("low drive in high power mode");
   AST_EXT_DRIVER_OFF: assert property (extMode |=> !soscOut.oscEnable && !soscOut.lowPower) // RQ6
      else $error("crystal driver on in external clock mode");
   AST_IDLE_OFF: assert property (oscModeOn && !periphDemand && !manEn_reg |=> !soscOut.oscEnable) // RQ2
      else $error("oscillator on without demand or enable");
   AST_XTAL_TICK: assert property (oscModeOn && soscOut.oscEnable && secondaryXtalTick |=> soscOut.clockTick) // RQ3
      else $error("crystal tick not passed");
   AST_NO_TICK_DIGIO: assert property (mode_reg == SCR_MODE_DIGIO |=> !soscOut.clockTick) // RQ4
      else $error("tick in digital mode");
   AST_EXT_ONLY_EDGE: assert property (extMode && !extRise |=> !soscOut.clockTick) // RQ6
      else $error("external tick without rising edge");

   // Reference divider, pin and primary oscillator checks
   AST_OE_OFF: assert property (!refCtl_reg.outEnable |=> refClockOe_n && !refClockOut) // RQ7
      else $error("reference pin driven while disabled");
   AST_OUT_LOW_OFF: assert property (refClockOe_n |-> !refClockOut) // RQ7
      else $error("reference output high while released");
   AST_CNT_CLEAR: assert property (!refAllowed |=> divCnt_reg == SCR_CNT_W'(0)) // RQ7
      else $error("divider not cleared while stopped");
   AST_SLEEP_RUN: assert property (refCtl_reg.outEnable && refCtl_reg.runInSleep && refCtl_reg.sourceSelect // RQ14
      |=> !refClockOe_n) else $error("reference output stopped in sleep");
   AST_SYS_BASE: assert property (!refCtl_reg.sourceSelect |-> baseTick == systemTick) // RQ16
      else $error("system clock not used as base");
   AST_PRI_BASE: assert property (refCtl_reg.sourceSelect && primaryOscRun |-> baseTick == primaryTick) // RQ11
      else $error("primary clock not used as base");
   AST_PRI_RUN: assert property (!sleepMode |=> primaryOscRun) // RQ15
      else $error("primary off while awake");
   AST_PRI_KEEP: assert property (primaryKeep_reg |=> primaryOscRun) // RQ15
      else $error("primary off despite keep bit");
   AST_PRI_OFF: assert property (sleepMode && !primaryKeep_reg |=> !primaryOscRun) // RQ15
      else $error("primary left running in sleep");
   AST_DIV_HOLD: assert property (refAllowed && !baseTick |=> $stable(refClockOut)) // RQ8
      else $error("output moved without base tick");
   AST_DIV_NO_EARLY: assert property (refAllowed && baseTick && !divWrap |=> $stable(refClockOut)) // RQ9
      else $error("output toggled before half period");
   AST_WRAP_AT_15: assert property (refAllowed && refCtl_reg.divisor == 4'h5 && divCnt_reg == SCR_CNT_W'(15) // RQ9
      |-> divWrap) else $error("divide by 32 misses its wrap");
   AST_WRAP_MAX: assert property (refAllowed && refCtl_reg.divisor == 4'hf && divCnt_reg < SCR_CNT_W'(16383) // RQ9
      |-> !divWrap) else $error("divide by 32768 wraps early");

   // Register bus checks
   AST_RD_IDLE: assert property (!busRdStb |=> busRdData == SCR_DW'(0)) // RQ18
      else $error("read data outside its cycle");
   AST_WR_REFCTL: assert property (busWrStb && busAddr == SCR_REG_REFCTL |=> // RQ8
      refCtl_reg.divisor == $past(busWrData[SCR_REF_DIV_LSB +: 4])) else $error("divisor write lost");
   AST_RD_REFCTL: assert property (busRdStb && busAddr == SCR_REG_REFCTL |=> // RQ7
      busRdData[SCR_REF_EN_BIT] == $past(refCtl_reg.outEnable)) else $error("enable bit read wrong");
   AST_RD_OSCCTL: assert property (busRdStb && busAddr == SCR_REG_OSCCTL |=> // RQ2
      busRdData[SCR_OSC_MANEN_BIT] == $past(manEn_reg)) else $error("manual enable read wrong");
   AST_STS_RO: assert property (busWrStb && busAddr == SCR_REG_STATUS |=> // RQ18
      $stable(refCtl_reg) && $stable(mode_reg)) else $error("status write changed control");

   COV_AUTO: cover property (periphDemand && oscModeOn ##1 soscOut.oscEnable);
   COV_EXT: cover property (soscOut.clockTick && extMode);
   COV_SLEEP_RUN: cover property (sleepMode && !refClockOe_n && refClockOut);
   COV_PRI_DOWN: cover property (sleepMode && !primaryOscRun && refCtl_reg.sourceSelect);
   COV_CLAMP: cover property (refAllowed && refCtl_reg.divisor < SCR_DIV_MIN_CODE && baseTick && divWrap);
endmodule
`default_nettype wire

// ==== scr_pkg.sv ====
// Constants, register map and carrier types for the secondary oscillator
// and reference clock output block.
// Assumes one 20 MHz system clock; the slower clocks arrive as enable ticks.
`default_nettype none
package scr_pkg;
   localparam int SCR_AW = 2;
   localparam int SCR_DW = 16;
   localparam int SCR_CNT_W = 15;
   localparam int SCR_CLK_MHZ = 20;

   localparam logic [SCR_AW-1:0] SCR_REG_REFCTL = 2'h0;
   localparam logic [SCR_AW-1:0] SCR_REG_OSCCTL = 2'h1;
   localparam logic [SCR_AW-1:0] SCR_REG_SOSCCFG = 2'h2;
   localparam logic [SCR_AW-1:0] SCR_REG_STATUS = 2'h3;

   localparam int SCR_REF_EN_BIT = 15;
   localparam int SCR_REF_SLP_BIT = 13;
   localparam int SCR_REF_SEL_BIT = 12;
   localparam int SCR_REF_DIV_LSB = 8;
   localparam int SCR_OSC_MANEN_BIT = 1;
   localparam int SCR_OSC_PKEEP_BIT = 2;
   localparam int SCR_SECONDARY_OSCILLATOR_MODE_LSB = 8;
   localparam int SCR_STS_OSC_ON = 0;
   localparam int SCR_STS_LOWPWR = 1;
   localparam int SCR_STS_DIGIO = 2;
   localparam int SCR_STS_REF_ON = 3;
   localparam int SCR_STS_PRI_ON = 4;

   localparam logic [SCR_DW-1:0] SCR_REFCTL_MASK = 16'hbf00;
   localparam logic [3:0] SCR_REF_DIV_RST = 4'h0;
   localparam logic SCR_BIT_RST = 1'b0;
   localparam logic [1:0] SCR_MODE_RST = 2'h0;
   localparam logic [3:0] SCR_DIV_MIN_CODE = 4'h5;

   typedef enum logic [1:0] {
      SCR_MODE_DIGIO = 2'h0,
      SCR_MODE_LOWPWR = 2'h1,
      SCR_MODE_EXTCLK = 2'h2,
      SCR_MODE_HIPWR = 2'h3
   } scr_mode_t;

   typedef struct packed {
      logic outEnable;
      logic runInSleep;
      logic sourceSelect;
      logic [3:0] divisor;
   } scr_ref_ctl_t;

   typedef struct packed {
      logic oscEnable;
      logic lowPower;
      logic pinsDigital;
      logic clockTick;
   } scr_secondary_oscillator_t;
endpackage
`default_nettype wire

// ==== scr_ref_sink.sv ====
// Far-side device clocked from the reference pin; measures its period.
// Assumes the pin is sampled in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module scr_ref_sink (
   input wire logic sys_clk,
   input wire logic refPin,
   output logic [15:0] lastPeriod
);
   logic prevReg = 1'b0;
   logic [15:0] cntReg = 16'h0;
   // Period in system clocks between rising edges
   always @(posedge sys_clk) begin
      prevReg <= refPin;
      if (refPin && !prevReg) begin
         lastPeriod <= cntReg + 16'h1;
         cntReg <= 16'h0;
      end else begin
         cntReg <= cntReg + 16'h1;
      end
   end
endmodule
`default_nettype wire

// ==== test_scr_clock_ctrl.sv ====
// Self-checking bench for the secondary oscillator and reference output.
// Assumes the register layout of scr_pkg and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_scr_clock_ctrl;
   import scr_pkg::*;
   typedef struct packed {
      logic [1:0] mode;
      logic manEn;
      logic demand;
      logic [2:0] expOsc;
   } scr_row_t;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [SCR_AW-1:0] busAddr = '0;
   logic [SCR_DW-1:0] busWrData = '0;
   logic busWrStb = 1'b0;
   logic busRdStb = 1'b0;
   logic periphDemand = 1'b0;
   logic sleepMode = 1'b0;
   logic systemTick = 1'b1;
   logic primaryTick = 1'b1;
   logic xtalTick = 1'b0;
   logic extClk = 1'b0;
   logic slowSys = 1'b0;
   logic [SCR_DW-1:0] busRdData;
   scr_secondary_oscillator_t soscOut;
   logic primaryOscRun;
   logic refClockOut;
   logic refClockOe_n;
   logic refPin;
   logic [15:0] period;
   logic [15:0] rdVal;
   logic [15:0] nTick;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int i;
   // Mode, manual enable, demand, expected {oscEnable, lowPower, pinsDigital}
   scr_row_t rows [5] = '{7'h19, 7'h2e, 7'h74, 7'h60, 7'h50};
   // Pull-down on the pin while it is released
   assign refPin = !refClockOe_n & refClockOut;
   scr_clock_ctrl u_scr_clock_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .busAddr(busAddr),
      .busWrData(busWrData), .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData),
      .periphDemand(periphDemand), .sleepMode(sleepMode), .systemTick(systemTick),
      .primaryTick(primaryTick), .secondaryXtalTick(xtalTick), .secondaryExtClockIn(extClk),
      .soscOut(soscOut), .primaryOscRun(primaryOscRun), .refClockOut(refClockOut),
      .refClockOe_n(refClockOe_n));
   scr_ref_sink u_scr_ref_sink (.sys_clk(sys_clk), .refPin(refPin), .lastPeriod(period));
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic results();
      if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Tick sources; a slowed system clock mimics a clock switch
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      xtalTick <= (cyc % 8 == 0);
      systemTick <= !slowSys || (cyc % 2 == 0);
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      busAddr <= a;
      busWrData <= d;
      busWrStb <= 1'b1;
      @(posedge sys_clk);
      busWrStb <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      busAddr <= a;
      busRdStb <= 1'b1;
      @(posedge sys_clk);
      busRdStb <= 1'b0;
      #1 d = busRdData;
   endtask
   task automatic ticks(input int n, output logic [15:0] t);
      t = 16'h0;
      repeat (n) begin
         @(posedge sys_clk);
         #1 t = t + {15'h0, soscOut.clockTick};
      end
   endtask
   // Four periods of settling, then the sink's last period
   task automatic measure(input logic [7:0] hi, input logic [15:0] expP, input string nm);
      wr(SCR_REG_REFCTL, {hi, 8'h00});
      repeat (4 * expP) @(posedge sys_clk);
      chk(nm, period, expP);
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(SCR_REG_REFCTL, rdVal);
      chk("refctl reset", rdVal, 16'h0000);
      chk("pin reset", {15'h0, refClockOe_n}, 16'h0001);
      wr(SCR_REG_REFCTL, 16'hffff);
      rd(SCR_REG_REFCTL, rdVal);
      chk("refctl bits", rdVal, 16'hbf00);
      for (i = 0; i < 5; i++) begin
         wr(SCR_REG_SOSCCFG, {6'h0, rows[i].mode, 8'h00});
         wr(SCR_REG_OSCCTL, {14'h0, rows[i].manEn, 1'b0});
         periphDemand <= rows[i].demand;
         repeat (3) @(posedge sys_clk);
         chk("secondary_oscillator row", {13'h0, soscOut[3:1]}, {13'h0, rows[i].expOsc});
      end
      // External clock mode: one tick per rising input edge
      extClk <= 1'b1;
      ticks(5, nTick);
      chk("ext tick", nTick, 16'h0001);
      wr(SCR_REG_SOSCCFG, 16'h0300);
      periphDemand <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ticks(16, nTick);
      chk("xtal tick", nTick, 16'h0002);
      rd(SCR_REG_SOSCCFG, rdVal);
      chk("mode read", rdVal, 16'h0300);
      measure(8'h85, 16'd32, "div 32");
      measure(8'h86, 16'd64, "div 64");
      measure(8'h80, 16'd32, "div clamp");
      slowSys <= 1'b1;
      measure(8'h85, 16'd64, "sys switch");
      slowSys <= 1'b0;
      measure(8'h95, 16'd32, "primary base");
      sleepMode <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk("primary sleep", {15'h0, primaryOscRun}, 16'h0000);
      chk("pin sleep", {15'h0, refClockOe_n}, 16'h0001);
      wr(SCR_REG_OSCCTL, 16'h0004);
      measure(8'hb5, 16'd32, "sleep run");
      rd(SCR_REG_STATUS, rdVal);
      chk("status", rdVal, 16'h0019);
      chk("primary kept", {15'h0, primaryOscRun}, 16'h0001);
      wr(SCR_REG_REFCTL, 16'ha500);
      repeat (3) @(posedge sys_clk);
      chk("sleep sys src", {15'h0, refClockOe_n}, 16'h0001);
      sleepMode <= 1'b0;
      wr(SCR_REG_REFCTL, 16'h0500);
      repeat (3) @(posedge sys_clk);
      chk("pin disabled", {15'h0, refClockOe_n}, 16'h0001);
      results();
   end
endmodule
`default_nettype wire
